/* hdl/gdm_pkg.sv */
// Package for the masked pin direction block: register map, field layout and reset values.
// Assumes an APB master with 32-bit data and byte strobes; nothing is imported by users.
package gdm_pkg;

   localparam int unsigned  PIN_COUNT     = 9;
   localparam int unsigned  APB_ADDR_W    = 8;
   localparam int unsigned  APB_DATA_W    = 32;
   localparam int unsigned  APB_STRB_W    = 4;
   localparam int unsigned  OCTET_W       = 8;

   localparam logic [7:0]   OFF_PIN_MODE  = 8'h00;
   localparam logic [7:0]   OFF_RESERVED  = 8'h04;
   localparam logic [7:0]   OFF_DIRECTION = 8'h08;

   localparam logic [31:0]  DIR_RESET     = 32'h00010F0F;
   localparam logic [31:0]  MODE_RESET    = 32'h00000000;

   localparam int unsigned  DIR_POS [0:8] = '{0, 1, 2, 3, 8, 9, 10, 11, 16};
   localparam int unsigned  MASK_POS[0:8] = '{4, 5, 6, 7, 12, 13, 14, 15, 20};

   localparam int unsigned  MODE_LSB      = 6;
   localparam int unsigned  MODE_W        = 2;
   localparam int unsigned  MODE_BITS     = PIN_COUNT * MODE_W;

   localparam logic [1:0]   MODE_GP_LOW   = 2'h0;
   localparam logic [1:0]   MODE_GP_HIGH  = 2'h1;
   localparam logic [1:0]   GP_CODE [0:8] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h1};

   localparam logic [8:0]   DIR_BITS_RESET    = 9'h1FF;
   localparam logic [17:0]  MODE_FIELDS_RESET = 18'h00000;
   localparam logic [8:0]   GP_SEL_RESET      = 9'h000;

   localparam logic [8:0]   OE_N_RESET    = 9'h1FF;
   localparam logic [8:0]   PIN_O_RESET   = 9'h000;

   typedef enum logic [1:0] {
      APB_IDLE   = 2'b00,
      APB_ACCESS = 2'b01,
      APB_DONE   = 2'b11
   } gdm_apb_state_type;

   typedef struct packed {
      logic [8:0] o;
      logic [8:0] oe_n;
   } gdm_pin_drive_type;

   typedef struct packed {
      logic [8:0] gp_out;
      logic [8:0] alt_out;
      logic [8:0] alt_oe_n;
   } gdm_pin_source_type;

endpackage

/* hdl/gdm_dir_block.sv */
// Masked pin direction register with its pin mode register, as an APB slave, and the pin drive stage.
// Assumes an APB master on ref_clk and pin sources that come from logic on the same clock.

`timescale 1ns/1ps

module gdm_dir_block (
   input  wire logic                          ref_clk,
   input  wire logic                          arst_n,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [gdm_pkg::APB_ADDR_W-1:0] paddr,
   input  wire logic [gdm_pkg::APB_DATA_W-1:0] pwdata,
   input  wire logic [gdm_pkg::APB_STRB_W-1:0] pstrb,
   output logic      [gdm_pkg::APB_DATA_W-1:0] prdata,
   output logic                               pready,
   output logic                               pslverr,
   input  gdm_pkg::gdm_pin_source_type        pin_source,
   output gdm_pkg::gdm_pin_drive_type         pin_drive,
   output logic      [gdm_pkg::PIN_COUNT-1:0]  dir_state,
   output logic      [gdm_pkg::PIN_COUNT-1:0]  gp_selected
);

   gdm_pkg::gdm_apb_state_type               state_reg;
   gdm_pkg::gdm_apb_state_type               state_next;
   logic [gdm_pkg::PIN_COUNT-1:0]             dir_reg;
   logic [gdm_pkg::PIN_COUNT-1:0]             dir_next;
   logic [gdm_pkg::MODE_BITS-1:0]             mode_reg;
   logic [gdm_pkg::MODE_BITS-1:0]             mode_next;
   logic [gdm_pkg::APB_DATA_W-1:0]            prdata_reg;
   logic [gdm_pkg::APB_DATA_W-1:0]            prdata_next;
   logic                                     pready_reg;
   logic                                     pready_next;
   logic                                     pslverr_reg;
   logic                                     pslverr_next;
   logic [gdm_pkg::PIN_COUNT-1:0]             pin_o_reg;
   logic [gdm_pkg::PIN_COUNT-1:0]             pin_o_next;
   logic [gdm_pkg::PIN_COUNT-1:0]             oe_n_reg;
   logic [gdm_pkg::PIN_COUNT-1:0]             oe_n_next;
   logic [gdm_pkg::PIN_COUNT-1:0]             gp_sel_reg;
   logic [gdm_pkg::PIN_COUNT-1:0]             gp_sel_next;

   wire logic                                hit_mode;
   wire logic                                hit_reserved;
   wire logic                                hit_dir;
   wire logic                                hit_any;
   wire logic                                access_start;
   wire logic                                access_commit;
   wire logic                                write_commit;
   wire logic                                dir_write;
   wire logic                                mode_write;
   wire logic [gdm_pkg::APB_DATA_W-1:0]       dir_read_word;
   wire logic [gdm_pkg::APB_DATA_W-1:0]       mode_read_word;
   wire logic [gdm_pkg::APB_DATA_W-1:0]       read_word;
   wire logic [gdm_pkg::PIN_COUNT-1:0]        dir_update;
   wire logic [gdm_pkg::PIN_COUNT-1:0]        gp_mode;
   wire logic [gdm_pkg::MODE_BITS-1:0]        mode_update;

   // Address decode. The reserved word answers without error so software can sweep the block.
   assign hit_mode      = (paddr == gdm_pkg::OFF_PIN_MODE);
   assign hit_reserved  = (paddr == gdm_pkg::OFF_RESERVED);
   assign hit_dir       = (paddr == gdm_pkg::OFF_DIRECTION);
   assign hit_any       = hit_mode | hit_reserved | hit_dir;

   // One wait state lets read data and the ready both leave flip-flops.
   assign access_start  = psel & penable & (state_reg == gdm_pkg::APB_IDLE);
   assign access_commit = psel & penable & pready_reg;
   assign write_commit  = access_commit & pwrite & ~pslverr_reg;
   assign dir_write     = write_commit & hit_dir;
   assign mode_write    = write_commit & hit_mode;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         gdm_pkg::APB_IDLE: begin
            if (access_start) begin
               state_next = gdm_pkg::APB_ACCESS;
            end
         end
         gdm_pkg::APB_ACCESS: begin
            state_next = gdm_pkg::APB_DONE;
         end
         gdm_pkg::APB_DONE: begin
            state_next = gdm_pkg::APB_IDLE;
         end
         default: begin
            state_next = gdm_pkg::APB_IDLE;
         end
      endcase
   end

   // Per pin masked update; a mask bit gates only its own direction bit and is never kept.
   genvar gi;
   generate
      for (gi = 0; gi < gdm_pkg::PIN_COUNT; gi = gi + 1) begin : g_pin
         localparam int unsigned DP = gdm_pkg::DIR_POS[gi];
         localparam int unsigned MP = gdm_pkg::MASK_POS[gi];
         localparam int unsigned ML = gdm_pkg::MODE_LSB + gi * gdm_pkg::MODE_W;
         localparam int unsigned FL = gi * gdm_pkg::MODE_W;

         // Mask and direction share one octet, so that octet's strobe alone enables the change.
         assign dir_update[gi] = dir_write & pwdata[MP] & pstrb[DP / gdm_pkg::OCTET_W];

         assign dir_read_word[DP] = dir_reg[gi];

         assign mode_update[FL +: gdm_pkg::MODE_W] =
            (mode_write & pstrb[ML / gdm_pkg::OCTET_W]) ? pwdata[ML +: gdm_pkg::MODE_W]
                                                         : mode_reg[FL +: gdm_pkg::MODE_W];

         assign mode_read_word[ML +: gdm_pkg::MODE_W] = mode_reg[FL +: gdm_pkg::MODE_W];

         // Pins 7 and 8 default to an alternate function; their general purpose code is 01.
         assign gp_mode[gi] = (mode_reg[FL +: gdm_pkg::MODE_W] == gdm_pkg::GP_CODE[gi]);
      end
   endgenerate

   // Mask bits and all other positions read as zero.
   assign dir_read_word[gdm_pkg::MASK_POS[0] +: 4]   = 4'h0;
   assign dir_read_word[gdm_pkg::MASK_POS[4] +: 4]   = 4'h0;
   assign dir_read_word[19:17]                      = 3'h0;
   assign dir_read_word[gdm_pkg::MASK_POS[8]]        = 1'b0;
   assign dir_read_word[31:21]                      = 11'h000;

   assign mode_read_word[gdm_pkg::MODE_LSB-1:0]     = 6'h00;
   assign mode_read_word[31:gdm_pkg::MODE_LSB+gdm_pkg::MODE_BITS] = 8'h00;

   assign read_word = hit_dir  ? dir_read_word :
                      hit_mode ? mode_read_word :
                                 32'h00000000;

   always_comb begin
      dir_next = dir_reg;
      for (int i = 0; i < gdm_pkg::PIN_COUNT; i = i + 1) begin
         if (dir_update[i]) begin
            dir_next[i] = pwdata[gdm_pkg::DIR_POS[i]];
         end
      end
   end

   // Reserved bits in a write are simply ignored, so a careless write harms nothing.
   assign mode_next    = mode_update;
   assign pready_next  = (state_next == gdm_pkg::APB_ACCESS);
   assign pslverr_next = access_start ? ~hit_any : (pslverr_reg & ~access_commit);
   assign prdata_next  = (access_start & ~pwrite & hit_any) ? read_word :
                         (access_commit ? 32'h00000000 : prdata_reg);

   // A pin follows its direction bit only in general purpose mode; otherwise the
   // alternate function owns the driver and the direction bit has no effect.
   assign gp_sel_next = gp_mode;
   assign oe_n_next   = (gp_mode & dir_reg) | (~gp_mode & pin_source.alt_oe_n);
   assign pin_o_next  = (gp_mode & pin_source.gp_out) | (~gp_mode & pin_source.alt_out);

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg   <= gdm_pkg::APB_IDLE;
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h00000000;
      end else begin
         state_reg   <= state_next;
         pready_reg  <= pready_next;
         pslverr_reg <= pslverr_next;
         prdata_reg  <= prdata_next;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         dir_reg  <= gdm_pkg::DIR_BITS_RESET;
         mode_reg <= gdm_pkg::MODE_FIELDS_RESET;
      end else begin
         dir_reg  <= dir_next;
         mode_reg <= mode_next;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         pin_o_reg  <= gdm_pkg::PIN_O_RESET;
         oe_n_reg   <= gdm_pkg::OE_N_RESET;
         gp_sel_reg <= gdm_pkg::GP_SEL_RESET;
      end else begin
         pin_o_reg  <= pin_o_next;
         oe_n_reg   <= oe_n_next;
         gp_sel_reg <= gp_sel_next;
      end
   end

   assign prdata         = prdata_reg;
   assign pready         = pready_reg;
   assign pslverr        = pslverr_reg;
   assign pin_drive.o    = pin_o_reg;
   assign pin_drive.oe_n = oe_n_reg;
   assign dir_state      = dir_reg;
   assign gp_selected    = gp_sel_reg;

endmodule // gdm_dir_block

/* bench/gdm_dir_assertions.sv */
// Concurrent checks on the masked pin direction block.
// Bound to the block's ports from the bench top; one clock, async reset.
`timescale 1ns/1ps
module gdm_dir_assertions (
   input wire logic                       ref_clk,
   input wire logic                       arst_n,
   input wire logic                       psel,
   input wire logic                       penable,
   input wire logic                       pwrite,
   input wire logic [7:0]                 paddr,
   input wire logic [31:0]                pwdata,
   input wire logic [3:0]                 pstrb,
   input wire logic [31:0]                prdata,
   input wire logic                       pready,
   input wire logic                       pslverr,
   input wire gdm_pkg::gdm_pin_source_type pin_source,
   input wire gdm_pkg::gdm_pin_drive_type  pin_drive,
   input wire logic [8:0]                 dir_state,
   input wire logic [8:0]                 gp_selected
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   wire wr_dir = psel && penable && pready && pwrite && !pslverr && paddr == 8'h08;
   wire rd_end = psel && penable && pready && !pwrite;
   a_ready_pulse: assert property (pready |=> !pready) else $error("ready longer than one cycle");
   a_one_wait: assert property (psel && $rose(penable) |-> !pready ##1 pready) else $error("wait state wrong");
   a_rsvd_quiet: assert property (rd_end && paddr == 8'h04 |-> prdata == 32'h0 && !pslverr)
      else $error("reserved word not quiet");
   a_mask_reads_zero: assert property (rd_end && paddr == 8'h08 |-> (prdata & ~32'h00010F0F) == 32'h0)
      else $error("mask or spare bits read nonzero");
   a_read_layout: assert property (rd_end && paddr == 8'h08 |-> prdata[16] == dir_state[8]
      && prdata[11:8] == dir_state[7:4] && prdata[3:0] == dir_state[3:0]) else $error("read layout wrong");
   a_dir_hold: assert property (!wr_dir |=> $stable(dir_state)) else $error("direction moved without write");
   a_pin0_masked: assert property (wr_dir && pstrb[0] |=> dir_state[0] ==
      ($past(pwdata[4]) ? $past(pwdata[0]) : $past(dir_state[0]))) else $error("pin 0 masked write wrong");
   a_pin4_masked: assert property (wr_dir && pstrb[1] |=> dir_state[4] ==
      ($past(pwdata[12]) ? $past(pwdata[8]) : $past(dir_state[4]))) else $error("pin 4 masked write wrong");
   a_pin8_masked: assert property (wr_dir && pstrb[2] |=> dir_state[8] ==
      ($past(pwdata[20]) ? $past(pwdata[16]) : $past(dir_state[8]))) else $error("pin 8 masked write wrong");
   a_gp_drive: assert property (gp_selected[0] && $past(gp_selected[0]) |->
      pin_drive.oe_n[0] == $past(dir_state[0]) && pin_drive.o[0] == $past(pin_source.gp_out[0]))
      else $error("pin 0 drive wrong");
   a_alt_drive: assert property (!gp_selected[8] && !$past(gp_selected[8]) && $past(arst_n, 2) |->
      pin_drive.oe_n[8] == $past(pin_source.alt_oe_n[8]) && pin_drive.o[8] == $past(pin_source.alt_out[8]))
      else $error("pin 8 alternate drive wrong");
endmodule // gdm_dir_assertions

/* bench/gdm_pin_pad.sv */
// External circuitry on the nine pins: each line has a pull-up.
// Assumes only the block drives the lines.
`timescale 1ns/1ps
module gdm_pin_pad (
   input wire gdm_pkg::gdm_pin_drive_type pin_drive,
   output logic [8:0]                    pin_level
);
   // An undriven line rises to the pull-up, so a stale value cannot pass.
   assign pin_level = pin_drive.oe_n | pin_drive.o;
endmodule // gdm_pin_pad

/* bench/tb.sv */
// Bench top: APB master tasks, pin pads and the bound checker.
// Assumes the block answers each transfer within a few cycles.
`timescale 1ns/1ps
module tb;
   logic                        ref_clk, arst_n, psel, penable, pwrite, pready, pslverr, rd_err;
   logic [7:0]                  paddr;
   logic [31:0]                 pwdata, prdata, rd_data, exp_dir;
   logic [3:0]                  pstrb;
   logic [8:0]                  dir_state, gp_selected, pin_level;
   gdm_pkg::gdm_pin_source_type pin_source;
   gdm_pkg::gdm_pin_drive_type  pin_drive;
   int                          err_total, samples_checked;
   gdm_dir_block gdm_dir_block_inst (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pin_source(pin_source), .pin_drive(pin_drive), .dir_state(dir_state),
      .gp_selected(gp_selected));
   gdm_pin_pad gdm_pin_pad_inst (.pin_drive(pin_drive), .pin_level(pin_level));
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_of_test();
      $display("Compared %0d values, %0d mismatches", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      rd_data = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Touches one pin through its own octet lane; reserved bits stay zero.
   task automatic set_pin(input int i, input logic v);
      int p;
      p = (i < 4) ? i : (i < 8) ? i + 4 : 16;
      apb(1'b1, 8'h08, (32'(v) << p) | (32'h1 << (p + 4)), 4'(1 << (p / 8)));
      exp_dir[p] = v;
   endtask
   initial begin
      #20us;
      err_total++;
      end_of_test();
   end
   initial begin
      {arst_n, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      pin_source = '{gp_out: 9'h054, alt_out: 9'h0AA, alt_oe_n: 9'h000};
      err_total = 0;
      samples_checked = 0;
      repeat (2) @(posedge ref_clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      chk(32'(gp_selected), 32'h0000007F);
      chk(32'(dir_state), 32'h000001FF);
      apb(1'b0, 8'h08, 32'h0, 4'h0);
      chk(rd_data, 32'h00010F0F);
      apb(1'b1, 8'h04, 32'h00101010, 4'hF);
      apb(1'b0, 8'h04, 32'h0, 4'h0);
      chk({rd_data[30:0], rd_err}, 32'h0);
      apb(1'b0, 8'h0C, 32'h0, 4'h0);
      chk({rd_data[30:0], rd_err}, 32'h1);
      apb(1'b1, 8'h08, 32'h00000000, 4'hF);
      apb(1'b0, 8'h08, 32'h0, 4'h0);
      chk(rd_data, 32'h00010F0F);
      exp_dir = 32'h00010F0F;
      for (int i = 0; i < 9; i++) begin
         set_pin(i, 1'b0);
         apb(1'b0, 8'h08, 32'h0, 4'h0);
         chk(rd_data, exp_dir);
      end
      repeat (3) @(posedge ref_clk);
      chk(32'(pin_level), 32'h000000D4);
      apb(1'b1, 8'h08, 32'h00110000, 4'h3);
      apb(1'b0, 8'h08, 32'h0, 4'h0);
      chk(rd_data, 32'h00000000);
      apb(1'b1, 8'h08, 32'h0011FFFF, 4'hF);
      repeat (3) @(posedge ref_clk);
      chk(32'(pin_level), 32'h000000FF);
      set_pin(8, 1'b0);
      apb(1'b1, 8'h00, 32'h00400000, 4'hF);
      repeat (3) @(posedge ref_clk);
      chk(32'(gp_selected), 32'h0000017F);
      chk(32'(pin_level), 32'h000000FF);
      end_of_test();
   end
endmodule // tb
bind gdm_dir_block gdm_dir_assertions gdm_dir_assertions_inst (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .pin_source(pin_source), .pin_drive(pin_drive), .dir_state(dir_state),
   .gp_selected(gp_selected));
